//--- design/hpsc_pkg.sv
// shared constants for the hot-plug slot capability and control bank
package hpsc_pkg;
	// register byte offsets in configuration space
	localparam logic [7:0] OFS_SLOT_CAP = 8'h7C;
	localparam logic [7:0] OFS_SLOT_CTL = 8'h80;
	// capability word field positions
	localparam int CAP_HP_CAPABLE = 6;
	localparam int CAP_PWR_VAL_LO = 7;
	localparam int CAP_PWR_VAL_HI = 14;
	localparam int CAP_PWR_SCL_LO = 15;
	localparam int CAP_PWR_SCL_HI = 16;
	localparam int CAP_NO_CMD_DONE = 18;
	localparam int CAP_SLOT_NUM_LO = 19;
	// capability low 19 bits after reset: presence flags 1Fh, limit 19h, scale 00b
	localparam logic [18:0] CAP_LOW_RST = 19'h00C9F;
	// control word field positions
	localparam int CTL_BTN_EN = 0;
	localparam int CTL_PFAULT_EN = 1;
	localparam int CTL_LATCH_EN = 2;
	localparam int CTL_PRES_EN = 3;
	localparam int CTL_CMD_EN = 4;
	localparam int CTL_HP_INT_EN = 5;
	localparam int CTL_ATTN_LO = 6;
	localparam int CTL_PIND_LO = 8;
	localparam int CTL_PWR_OFF = 10;
	localparam int CTL_LOCK_EN = 11;
	localparam int CTL_DLL_EN = 12;
	// writable control bits; 15:13 read as zero
	localparam logic [15:0] CTL_RW_MASK = 16'h1FFF;
	// indicator encodings
	localparam logic [1:0] IND_ON = 2'h1;
	localparam logic [1:0] IND_BLINK = 2'h2;
	localparam logic [1:0] IND_OFF = 2'h3;
	// latch event enable reset value decides the indicator and power defaults
	localparam logic LATCH_EN_RST = 1'h0;
	localparam logic [1:0] PIND_RST = LATCH_EN_RST ? IND_OFF : IND_ON;
	localparam logic [15:0] CTL_RST = {5'h00, LATCH_EN_RST, PIND_RST, IND_OFF, 6'h00};
	// event flag indices inside the flag vector
	localparam int FL_BTN = 0;
	localparam int FL_PFAULT = 1;
	localparam int FL_LATCH = 2;
	localparam int FL_PRES = 3;
	localparam int FL_CMD = 4;
	localparam int FL_DLL = 5;
	localparam int NUM_FL = 6;
	// flag positions in the upper half of the control word offset
	localparam int ST_FLAG_LO = 16;
	localparam int ST_DLL_POS = 24;
	// synchronised pin inputs: five events, interlock event, expander strap
	localparam int NUM_PIN = 7;
	localparam int PIN_LOCK = 5;
	localparam int PIN_EXP = 6;
endpackage

//--- design/hpsc_slot_regs.sv
`timescale 1ns/1ps
module hpsc_slot_regs #(
	parameter logic [12:0] SLOT_NUM = 13'h0002 // physical slot number of this port
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic cfg_wr_i, // configuration write strobe
	input wire logic cfg_rd_i, // configuration read strobe
	input wire logic [7:0] cfg_addr_i, // byte offset, dword aligned
	input wire logic [3:0] cfg_be_i, // byte enables
	input wire logic [31:0] cfg_wdata_i,
	output logic [31:0] cfg_rdata_o, // valid the cycle after cfg_rd_i
	input wire logic pre_wr_i, // preload write from eeprom or smbus
	input wire logic [7:0] pre_addr_i,
	input wire logic [31:0] pre_wdata_i,
	input wire logic btn_press_i, // expander pins, asynchronous levels
	input wire logic pwr_fault_i,
	input wire logic retention_latch_chg_i,
	input wire logic presence_chg_i,
	input wire logic cmd_done_i,
	input wire logic electromech_lock_evt_i,
	input wire logic expander_present_i,
	input wire logic link_active_i, // link layer status, same clock
	output logic hp_int_o,
	output logic wake_o,
	output logic [1:0] attn_ind_o,
	output logic [1:0] pwr_ind_o,
	output logic slot_pwr_off_o,
	output logic [7:0] pwr_lim_val_o,
	output logic [1:0] pwr_lim_scl_o,
	output logic msg_pwr_lim_o, // one-cycle message requests
	output logic msg_attn_o,
	output logic msg_pwr_ind_o
);
	import hpsc_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// state
	logic [NUM_PIN-1:0] sync1_q, sync1_d; // first synchroniser stage
	logic [NUM_PIN-1:0] sync2_q, sync2_d; // second stage, safe to use
	logic [PIN_LOCK:0] prev_q, prev_d; // last value for edge detection
	logic dll_prev_q, dll_prev_d; // last link-active value
	logic [18:0] cap_q, cap_d; // preloadable low capability bits
	logic hpcap_q, hpcap_d; // hot-plug capable as read
	logic [15:0] ctl_q, ctl_d; // slot control word
	logic [NUM_FL-1:0] flags_q, flags_d; // sticky slot events
	logic [31:0] rdata_q, rdata_d;
	logic int_q, int_d;
	logic wake_q, wake_d;
	logic lim_msg_q, lim_msg_d;
	logic attn_msg_q, attn_msg_d;
	logic pind_msg_q, pind_msg_d;

	////////////////////////////////////////////////////////////////////////////
	// decode
	logic cap_cfg_wr, ctl_cfg_wr, cap_pre_wr, ctl_pre_wr;
	logic [NUM_FL-1:0] evt, clr, en;
	logic [31:0] cap_word;

	assign cap_cfg_wr = cfg_wr_i && (cfg_addr_i == OFS_SLOT_CAP);
	assign ctl_cfg_wr = cfg_wr_i && (cfg_addr_i == OFS_SLOT_CTL);
	assign cap_pre_wr = pre_wr_i && (pre_addr_i == OFS_SLOT_CAP);
	assign ctl_pre_wr = pre_wr_i && (pre_addr_i == OFS_SLOT_CTL);
	// read view of the capability word; the slot number is fixed per port
	assign cap_word = {SLOT_NUM, cap_q[18:7], hpcap_q, cap_q[5:0]};

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and event detection
	always_comb begin
		sync1_d = {expander_present_i, electromech_lock_evt_i, cmd_done_i, presence_chg_i,
			retention_latch_chg_i, pwr_fault_i, btn_press_i};
		sync2_d = sync1_q;
		prev_d = sync2_q[PIN_LOCK:0];
		dll_prev_d = link_active_i;
		// rising edge of each of the five synchronised event lines is one event
		evt[FL_CMD:FL_BTN] = sync2_q[FL_CMD:FL_BTN] & ~prev_q[FL_CMD:FL_BTN];
		evt[FL_DLL] = link_active_i ^ dll_prev_q;
	end

	////////////////////////////////////////////////////////////////////////////
	// capability word: read-only to software, loaded only by preload
	always_comb begin
		cap_d = cap_q;
		if (cap_pre_wr) begin
			cap_d = pre_wdata_i[18:0];
		end
		// capable only while the expander is strapped in
		hpcap_d = cap_q[CAP_HP_CAPABLE] & sync2_q[PIN_EXP];
		// a write of either limit field, from either path, sends the message
		lim_msg_d = (cap_cfg_wr && (cfg_be_i[2:0] != 3'h0)) || cap_pre_wr;
	end

	////////////////////////////////////////////////////////////////////////////
	// control word and message requests
	always_comb begin
		ctl_d = ctl_q;
		attn_msg_d = 1'b0;
		pind_msg_d = 1'b0;
		if (ctl_pre_wr) begin
			ctl_d = pre_wdata_i[15:0] & CTL_RW_MASK;
			attn_msg_d = 1'b1;
			pind_msg_d = 1'b1;
		end else if (ctl_cfg_wr) begin
			// byte lane 0 holds enables and attention field
			if (cfg_be_i[0]) begin
				ctl_d[7:0] = cfg_wdata_i[7:0];
				attn_msg_d = 1'b1;
			end
			// byte lane 1 holds power indicator, power and late enables
			if (cfg_be_i[1]) begin
				ctl_d[15:8] = cfg_wdata_i[15:8] & CTL_RW_MASK[15:8];
				pind_msg_d = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// event flags: write-one-to-clear, a new event beats the clear
	always_comb begin
		clr = '0;
		if (ctl_cfg_wr) begin
			if (cfg_be_i[2]) begin
				clr[FL_CMD:FL_BTN] = cfg_wdata_i[ST_FLAG_LO+FL_CMD:ST_FLAG_LO];
			end
			if (cfg_be_i[3]) begin
				clr[FL_DLL] = cfg_wdata_i[ST_DLL_POS];
			end
		end
		flags_d = (flags_q & ~clr) | evt;
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt and wake-up
	always_comb begin
		en[FL_BTN] = ctl_q[CTL_BTN_EN];
		en[FL_PFAULT] = ctl_q[CTL_PFAULT_EN];
		en[FL_LATCH] = ctl_q[CTL_LATCH_EN];
		en[FL_PRES] = ctl_q[CTL_PRES_EN];
		// completion is only reported when the slot supports it
		en[FL_CMD] = ctl_q[CTL_CMD_EN] & ~cap_q[CAP_NO_CMD_DONE];
		en[FL_DLL] = ctl_q[CTL_DLL_EN];
		// level interrupt: drops once every enabled flag is cleared
		int_d = ctl_q[CTL_HP_INT_EN] & (|(flags_q & en));
		// wake is not gated by the master enable; the interlock has no flag
		wake_d = (|(flags_q & en)) | (ctl_q[CTL_LOCK_EN] & sync2_q[PIN_LOCK] &
			~prev_q[PIN_LOCK]);
	end

	////////////////////////////////////////////////////////////////////////////
	// read data: registered, unmapped offsets read zero
	always_comb begin
		rdata_d = rdata_q;
		if (cfg_rd_i) begin
			unique case (cfg_addr_i)
				OFS_SLOT_CAP: rdata_d = cap_word;
				OFS_SLOT_CTL: rdata_d = {7'h00, flags_q[FL_DLL], 3'h0,
					flags_q[FL_CMD:FL_BTN], ctl_q & CTL_RW_MASK};
				default: rdata_d = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q <= '0;
			dll_prev_q <= 1'b0;
			cap_q <= CAP_LOW_RST;
			hpcap_q <= 1'b0;
			ctl_q <= CTL_RST;
			flags_q <= '0;
			rdata_q <= 32'h0000_0000;
			int_q <= 1'b0;
			wake_q <= 1'b0;
			lim_msg_q <= 1'b0;
			attn_msg_q <= 1'b0;
			pind_msg_q <= 1'b0;
		end else begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			prev_q <= prev_d;
			dll_prev_q <= dll_prev_d;
			cap_q <= cap_d;
			hpcap_q <= hpcap_d;
			ctl_q <= ctl_d;
			flags_q <= flags_d;
			rdata_q <= rdata_d;
			int_q <= int_d;
			wake_q <= wake_d;
			lim_msg_q <= lim_msg_d;
			attn_msg_q <= attn_msg_d;
			pind_msg_q <= pind_msg_d;
		end
	end

	// outputs straight from flops
	assign cfg_rdata_o = rdata_q;
	assign hp_int_o = int_q;
	assign wake_o = wake_q;
	assign attn_ind_o = ctl_q[CTL_ATTN_LO+1:CTL_ATTN_LO];
	assign pwr_ind_o = ctl_q[CTL_PIND_LO+1:CTL_PIND_LO];
	assign slot_pwr_off_o = ctl_q[CTL_PWR_OFF];
	assign pwr_lim_val_o = cap_q[CAP_PWR_VAL_HI:CAP_PWR_VAL_LO];
	assign pwr_lim_scl_o = cap_q[CAP_PWR_SCL_HI:CAP_PWR_SCL_LO];
	assign msg_pwr_lim_o = lim_msg_q;
	assign msg_attn_o = attn_msg_q;
	assign msg_pwr_ind_o = pind_msg_q;

	////////////////////////////////////////////////////////////////////////////
	// assertions
	AST_INT_NEEDS_GATE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		hp_int_o |-> $past(ctl_q[CTL_HP_INT_EN]))
		else $error("interrupt raised while master enable was clear");
	AST_INT_FOLLOWS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(ctl_q[CTL_HP_INT_EN] && flags_q[FL_BTN] && ctl_q[CTL_BTN_EN]) |=> hp_int_o)
		else $error("enabled flag did not raise interrupt");
	AST_CMD_MASKED: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(cap_q[CAP_NO_CMD_DONE] && flags_q == 6'h10) |=> !hp_int_o)
		else $error("completion interrupt despite no-completion support");
	AST_LINK_EVT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(link_active_i != dll_prev_q) |=> flags_q[FL_DLL])
		else $error("link change did not set its flag");
	AST_W1C: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(ctl_cfg_wr && !cfg_rd_i && cfg_be_i[2] && cfg_wdata_i[ST_FLAG_LO] && !evt[FL_BTN])
		|=> !flags_q[FL_BTN])
		else $error("button flag not cleared by write of one");
	AST_SET_WINS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		evt[FL_PFAULT] |=> flags_q[FL_PFAULT])
		else $error("fault event lost");
	AST_LIM_MSG: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(cap_cfg_wr && cfg_be_i[1]) |=> msg_pwr_lim_o ##1
		(!msg_pwr_lim_o || $past(cap_cfg_wr || cap_pre_wr)))
		else $error("power limit message missing or stuck");
	AST_CAP_RO: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(cap_cfg_wr && !pre_wr_i) |=> $stable(cap_q))
		else $error("capability changed by software write");
	AST_HP_CAP: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		!sync2_q[PIN_EXP] |=> !cap_word[CAP_HP_CAPABLE])
		else $error("hot-plug capable set without expander");
	AST_ATTN_MSG: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(ctl_cfg_wr && !pre_wr_i && cfg_be_i[0]) |=>
		(msg_attn_o && attn_ind_o == $past(cfg_wdata_i[CTL_ATTN_LO+1:CTL_ATTN_LO])))
		else $error("attention message or state wrong");
	COV_INT: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) $rose(hp_int_o));
	COV_LINK: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) $rose(flags_q[FL_DLL]));
	COV_LIM: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) msg_pwr_lim_o);
	COV_WAKE: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) $rose(wake_o));
	COV_CMD_MASKED: cover property (@(posedge clk_sys_i) disable iff (!resetn_i)
		cap_q[CAP_NO_CMD_DONE] && flags_q[FL_CMD]);

	////////////////////////////////////////////////////////////////////////////
	// indicator and power control writes
	AST_PIND_MSG: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(ctl_cfg_wr && !pre_wr_i && cfg_be_i[1]) |=>
		(msg_pwr_ind_o && pwr_ind_o == $past(cfg_wdata_i[CTL_PIND_LO+1:CTL_PIND_LO])))
		else $error("power indicator message or state wrong");
	AST_PWR_CTL: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(ctl_cfg_wr && !pre_wr_i && cfg_be_i[1]) |=>
		(slot_pwr_off_o == $past(cfg_wdata_i[CTL_PWR_OFF])))
		else $error("slot power control not taken from write");
	// an idle bus must leave every message request low, or the port would spam the link
	AST_NO_MSG: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(!cfg_wr_i && !pre_wr_i) |=> (!msg_pwr_lim_o && !msg_attn_o && !msg_pwr_ind_o))
		else $error("message request without a write");

	////////////////////////////////////////////////////////////////////////////
	// capability view and preload
	AST_SLOT_NUM: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(cfg_rd_i && cfg_addr_i == OFS_SLOT_CAP) |=>
		(cfg_rdata_o[31:CAP_SLOT_NUM_LO] == SLOT_NUM))
		else $error("slot number wrong in capability read");
	AST_PRELOAD: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		cap_pre_wr |=> (cap_q == $past(pre_wdata_i[18:0])))
		else $error("preload did not land in the capability bits");

	////////////////////////////////////////////////////////////////////////////
	// event flags, interrupt and wake-up
	AST_FLAG_STICKY: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(flags_q[FL_PRES] && !ctl_cfg_wr) |=> flags_q[FL_PRES])
		else $error("presence flag dropped without a clear");
	AST_INT_DROPS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		((flags_q & en) == 6'h00) |=> !hp_int_o)
		else $error("interrupt stayed high with no enabled flag");
	AST_WAKE_LOCK: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
		(ctl_q[CTL_LOCK_EN] && sync2_q[PIN_LOCK] && !prev_q[PIN_LOCK]) |=> wake_o)
		else $error("interlock event did not raise wake-up");
endmodule

//--- verification/hpsc_slot_hw.sv
`timescale 1ns/1ps
// slot hardware behind the i/o expander, seen as plain levels
module hpsc_slot_hw (
	input wire logic clk_sys_i,
	input wire logic [6:0] evt_req_i, // 0-4 events, 5 interlock, 6 link toggle
	input wire logic strap_i, // expander fitted
	output logic [5:0] pin_o,
	output logic expander_present_o,
	output logic link_active_o
);
	// hold counters per pin; a short blip would be lost in the synchroniser
	logic [5:0][2:0] hold_q = '0;
	logic link_q = 1'h0;
	////////////////////////////////////////////////////////////////////////
	// stretch each pin request (0-5) into a five-cycle level; request 6 toggles the link
	always @(posedge clk_sys_i) begin
		for (int i = 0; i < 6; i++) begin
			hold_q[i] <= evt_req_i[i] ? 3'h5 : (hold_q[i] != 3'h0 ? hold_q[i] - 3'h1 : 3'h0);
		end
		link_q <= link_q ^ evt_req_i[6];
	end
	// pins and strap seen by the port
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pin_o[i] = hold_q[i] != 3'h0;
		end
	end
	assign expander_present_o = strap_i;
	assign link_active_o = link_q;
endmodule

//--- verification/hpsc_slot_regs_test.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin errors++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, gt); end end
module hpsc_slot_regs_test;
	import hpsc_pkg::*;
	logic clk_sys_i = 1'h0;
	logic resetn_i = 1'h0;
	logic cfg_wr_i = 1'h0, cfg_rd_i = 1'h0, pre_wr_i = 1'h0, strap = 1'h0;
	logic [7:0] cfg_addr_i = 8'h00, pre_addr_i = 8'h00;
	logic [3:0] cfg_be_i = 4'h0;
	logic [31:0] cfg_wdata_i = 32'h0, pre_wdata_i = 32'h0, cfg_rdata_o, rnd = 32'h00016529, e;
	logic [6:0] evt_req = 7'h00;
	logic [5:0] pin;
	logic exp_pres, link_act, hp_int_o, wake_o, wake_prev = 1'h0;
	logic [1:0] attn_ind_o, pwr_ind_o, pwr_lim_scl_o;
	logic slot_pwr_off_o, msg_pwr_lim_o, msg_attn_o, msg_pwr_ind_o;
	logic [7:0] pwr_lim_val_o;
	// capability low bits as the bench believes them: scale, limit, flags
	logic [18:0] cap_low = {4'h0, 8'h19, 7'h00} | 19'h0001F;
	logic [31:0] exp_q[$];
	string name_q[$], n;
	int errors = 0, check_count = 0, n_lim = 0, n_attn = 0, n_pind = 0, n_wake = 0;
	int x_lim = 0, x_attn = 0, x_pind = 0, w0;
	// event table: control word, event, interrupt, flags to clear, wake (2 = unchecked)
	logic [15:0] t_ctl[9] = '{16'h01E1, 16'h01E2, 16'h01E4, 16'h01E8, 16'h01F0,
		16'h01C1, 16'h01E1, 16'h11E0, 16'h09C0};
	int t_ev[9] = '{0, 1, 2, 3, 4, 0, 1, 6, 5};
	logic t_int[9] = '{1, 1, 1, 1, 1, 0, 0, 1, 0};
	logic [31:0] t_clr[9] = '{32'h10000, 32'h20000, 32'h40000, 32'h80000, 32'h100000,
		32'h10000, 32'h20000, 32'h1000000, 32'h0};
	int t_wake[9] = '{1, 1, 1, 1, 2, 1, 0, 1, 1};
	hpsc_slot_regs uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cfg_wr_i(cfg_wr_i),
		.cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
		.cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .pre_wr_i(pre_wr_i),
		.pre_addr_i(pre_addr_i), .pre_wdata_i(pre_wdata_i), .btn_press_i(pin[0]),
		.pwr_fault_i(pin[1]), .retention_latch_chg_i(pin[2]), .presence_chg_i(pin[3]),
		.cmd_done_i(pin[4]), .electromech_lock_evt_i(pin[5]), .expander_present_i(exp_pres),
		.link_active_i(link_act), .hp_int_o(hp_int_o), .wake_o(wake_o),
		.attn_ind_o(attn_ind_o), .pwr_ind_o(pwr_ind_o),
		.slot_pwr_off_o(slot_pwr_off_o), .pwr_lim_val_o(pwr_lim_val_o),
		.pwr_lim_scl_o(pwr_lim_scl_o), .msg_pwr_lim_o(msg_pwr_lim_o),
		.msg_attn_o(msg_attn_o), .msg_pwr_ind_o(msg_pwr_ind_o));
	hpsc_slot_hw hw (.clk_sys_i(clk_sys_i), .evt_req_i(evt_req), .strap_i(strap),
		.pin_o(pin), .expander_present_o(exp_pres), .link_active_o(link_act));
	////////////////////////////////////////////////////////////////////////
	initial begin
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	// count one-cycle messages; a stretched pulse shows up as an extra count
	always @(posedge clk_sys_i) begin
		n_lim += msg_pwr_lim_o;
		n_attn += msg_attn_o;
		n_pind += msg_pwr_ind_o;
		wake_prev <= wake_o;
		if (wake_o && !wake_prev) begin
			n_wake++;
		end
	end
	// read data monitor: oldest note against the registered answer
	initial begin
		forever begin
			@(posedge clk_sys_i iff cfg_rd_i);
			repeat (2) @(negedge clk_sys_i);
			e = exp_q.pop_front();
			n = name_q.pop_front();
			`CHK(n, e, cfg_rdata_o)
		end
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] cap_exp();
		return {13'h0002, cap_low[18:7], cap_low[6] & strap, cap_low[5:0]};
	endfunction
	// pseudo-random stimulus source
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		x_lim += (a == OFS_SLOT_CAP && be[2:0] != 3'h0);
		x_attn += (a == OFS_SLOT_CTL && be[0]);
		x_pind += (a == OFS_SLOT_CTL && be[1]);
		@(posedge clk_sys_i);
		cfg_wr_i <= 1'h1;
		cfg_addr_i <= a;
		cfg_be_i <= be;
		cfg_wdata_i <= d;
		@(posedge clk_sys_i);
		cfg_wr_i <= 1'h0;
	endtask
	task automatic cfg_read(input logic [7:0] a, input logic [31:0] x, input string nm);
		exp_q.push_back(x);
		name_q.push_back(nm);
		@(posedge clk_sys_i);
		cfg_rd_i <= 1'h1;
		cfg_addr_i <= a;
		@(posedge clk_sys_i);
		cfg_rd_i <= 1'h0;
		repeat (3) @(posedge clk_sys_i);
	endtask
	// preload one word from the serial side; a control preload sends both indicator messages
	task automatic preload(input logic [7:0] a, input logic [31:0] d);
		if (a == OFS_SLOT_CAP) begin
			cap_low = d[18:0];
			x_lim++;
		end else begin
			x_attn++;
			x_pind++;
		end
		@(posedge clk_sys_i);
		pre_wr_i <= 1'h1;
		pre_addr_i <= a;
		pre_wdata_i <= d;
		@(posedge clk_sys_i);
		pre_wr_i <= 1'h0;
		repeat (4) @(posedge clk_sys_i);
	endtask
	task automatic run_case(input int i);
		cfg_write(OFS_SLOT_CTL, 4'h3, {16'h0, t_ctl[i]});
		w0 = n_wake;
		@(posedge clk_sys_i);
		evt_req <= 7'h01 << t_ev[i];
		@(posedge clk_sys_i);
		evt_req <= 7'h00;
		repeat (10) @(negedge clk_sys_i);
		`CHK("interrupt", t_int[i], hp_int_o)
		if (t_wake[i] != 2) `CHK("wake", t_wake[i], n_wake - w0)
		cfg_read(OFS_SLOT_CTL, {16'h0, t_ctl[i]} | t_clr[i], "flags");
		cfg_write(OFS_SLOT_CTL, 4'hC, t_clr[i]);
		repeat (4) @(negedge clk_sys_i);
		`CHK("int cleared", 1'h0, hp_int_o)
		cfg_read(OFS_SLOT_CTL, {16'h0, t_ctl[i]}, "cleared");
	endtask
	task automatic stop_test();
		if (errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge clk_sys_i);
		errors++;
		stop_test();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (4) @(posedge clk_sys_i);
		resetn_i <= 1'h1;
		@(negedge clk_sys_i);
		`CHK("attn", 2'h3, attn_ind_o)
		`CHK("pind", 2'h1, pwr_ind_o)
		`CHK("pwroff", 1'h0, slot_pwr_off_o)
		`CHK("limit", 10'h019, {pwr_lim_scl_o, pwr_lim_val_o})
		cfg_read(OFS_SLOT_CAP, cap_exp(), "cap");
		cfg_read(OFS_SLOT_CTL, 32'h000001C0, "ctl");
		rnd = lfsr_next(rnd);
		cfg_write(OFS_SLOT_CAP, 4'hF, rnd);
		cfg_read(OFS_SLOT_CAP, cap_exp(), "cap ro");
		for (int v = 1; v < 4; v++) begin
			cfg_write(OFS_SLOT_CTL, 4'h3, {21'h0, v[0], v[1:0], v[1:0], 6'h0});
			@(negedge clk_sys_i);
			`CHK("ind", {v[1:0], v[1:0], v[0]}, {attn_ind_o, pwr_ind_o, slot_pwr_off_o})
		end
		rnd = lfsr_next(rnd);
		preload(OFS_SLOT_CAP, {13'h1FFF, 1'h0, rnd[17:7], 1'h1, rnd[5:0]});
		cfg_read(OFS_SLOT_CAP, cap_exp(), "no expander");
		`CHK("limit", cap_low[16:7], {pwr_lim_scl_o, pwr_lim_val_o})
		strap <= 1'h1;
		repeat (4) @(posedge clk_sys_i);
		cfg_read(OFS_SLOT_CAP, cap_exp(), "expander");
		for (int i = 0; i < 9; i++) begin
			run_case(i);
		end
		preload(OFS_SLOT_CAP, {13'h1FFF, cap_low | 19'h40000});
		t_int[4] = 1'h0;
		run_case(4);
		rnd = lfsr_next(rnd);
		preload(OFS_SLOT_CTL, rnd);
		cfg_read(OFS_SLOT_CTL, {16'h0, rnd[15:0] & CTL_RW_MASK}, "ctl preload");
		`CHK("ind preload", rnd[9:6], {pwr_ind_o, attn_ind_o})
		`CHK("lim msgs", x_lim, n_lim)
		`CHK("attn msgs", x_attn, n_attn)
		`CHK("pind msgs", x_pind, n_pind)
		stop_test();
	end
endmodule
